// [hdl/csds_pkg.sv]
// Package for the sensing scheduler and debug stream block.
// Assumes a 50 MHz mclk; timing counts are derived from these values in csds_top.
package csds_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int EVENT_PULSE_US = 1600;
    localparam int BOOST_US = 9100;
    localparam int BOOST_FIXED_US = 64000;
    localparam int NORMAL_US = 128000;
    localparam int LOW1_US = 256000;
    localparam int LOW2_US = 512000;
    localparam int HALT_S_00 = 20;
    localparam int HALT_S_01 = 40;
    localparam int HALT_S_11 = 3;

    // ------------------------------------------------------------
    // Tuning targets and framing
    // ------------------------------------------------------------
    localparam logic [15:0] TARGET_DEFAULT = 16'h04B0;
    localparam logic [15:0] TARGET_LOW = 16'h0400;
    localparam logic [7:0] SYNC_BYTE = 8'hAA;
    localparam int DATA_BYTES = 8;
    localparam logic [6:0] I2C_ADDR = 7'h44;

    // ------------------------------------------------------------
    // Flag and detection byte field positions (within byte)
    // ------------------------------------------------------------
    localparam int FLG_ACTIVE_HIGH = 5;
    localparam int FLG_FILTER_HALT = 4;
    localparam int FLG_LOW_POWER = 3;
    localparam int FLG_TUNE_BUSY = 2;
    localparam int FLG_NOISE = 1;
    localparam int FLG_ZOOM = 0;
    localparam int DET_TOUCH = 7;
    localparam int DET_PROX = 6;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [1:0] HALT_20S = 2'h0;
    localparam logic [1:0] HALT_40S = 2'h1;
    localparam logic [1:0] HALT_NEVER = 2'h2;
    localparam logic [1:0] HALT_3S = 2'h3;
    localparam logic [1:0] PWR_BOOST = 2'h0;
    localparam logic [1:0] PWR_NORMAL = 2'h1;
    localparam logic [1:0] PWR_LOW1 = 2'h2;
    localparam logic [1:0] PWR_LOW2 = 2'h3;

    typedef enum logic [2:0] {
        CSDS_TX_IDLE,
        CSDS_TX_START,
        CSDS_TX_BITS,
        CSDS_TX_STOP
    } csds_tx_t;

endpackage

// [hdl/csds_fifo.sv]
// Small synchronous FIFO used in the stream data path.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/100ps
module csds_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("DEPTH must be a power of two, at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;
    logic push;
    logic pop;

    always_comb begin
        in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
        out_valid = wr_ptr != rd_ptr;
        out_data = mem[rd_ptr[AW-1:0]];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // Storage carries no reset; only pointers define contents
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule

// [hdl/csds_top.sv]
// Sensing scheduler and 1-wire / I2C debug stream of a capacitive
// proximity controller. Assumes measurement results arrive as a pulse
// with sample data; an I2C target engine outside reads stream bytes.
`timescale 1ns/100ps
module csds_top
    import csds_pkg::*;
#(
    parameter int BIT_CYC = 500,
    parameter int START_CYC = 1000,
    parameter int MS_CYC = 50_000,
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Configuration bits
    input wire logic cfg_target_low,
    input wire logic cfg_partial_tune,
    input wire logic cfg_fast_touch,
    input wire logic [1:0] cfg_halt_time,
    input wire logic [1:0] cfg_power_mode,
    input wire logic cfg_zoom_disable,
    input wire logic cfg_stream_en,
    input wire logic cfg_stream_i2c,
    input wire logic cfg_event_mode,
    input wire logic cfg_active_high,
    // Measurement side
    input wire logic sample_valid,
    input wire logic [15:0] sample_counts,
    input wire logic [15:0] long_term_average,
    input wire logic prox_raw,
    input wire logic touch_raw,
    input wire logic noise_found,
    input wire logic [5:0] multipliers,
    input wire logic [7:0] compensation,
    input wire logic counts_out_of_range,
    input wire logic tune_done,
    // Scheduler controls to the measurement side
    output logic charge_start,
    output logic tune_start,
    output logic tune_partial,
    output logic [15:0] tune_target,
    output logic ltavg_hold,
    output logic reseed,
    output logic ac_filter_en,
    output logic reseed_delay_en,
    output logic in_zoom,
    // I2C streaming data port
    output logic [6:0] i2c_target_addr,
    output logic i2c_byte_valid,
    output logic [7:0] i2c_byte,
    input wire logic i2c_byte_ready,
    // Detection / stream pin, three-signal form
    input wire logic event_out_pin_in,
    output logic event_out_pin_o,
    output logic event_out_pin_oe,
    // Status
    output logic tuning_busy,
    output logic prox_det,
    output logic touch_det
);
    initial begin
        if (BIT_CYC < 1 || START_CYC < 1 || MS_CYC < 1 ||
            FIFO_DEPTH < 9) begin
            $error("csds_top: bad parameter value");
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] ms_to_cyc(input int us);
        ms_to_cyc = 32'((longint'(us) * MS_CYC) / 1000);
    endfunction

    function automatic logic [31:0] halt_cyc(input logic [1:0] sel);
        case (sel)
            HALT_20S: halt_cyc = 32'(HALT_S_00 * 1000 * MS_CYC);
            HALT_40S: halt_cyc = 32'(HALT_S_01 * 1000 * MS_CYC);
            HALT_3S: halt_cyc = 32'(HALT_S_11 * 1000 * MS_CYC);
            default: halt_cyc = '1;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Tuning and sample scheduling
    // ------------------------------------------------------------
    logic tune_busy_r, next_tune_busy;
    logic startup, next_startup;
    logic [31:0] intv_cnt, next_intv_cnt;
    logic [31:0] intv_len;
    logic charge_r, next_charge;
    logic tstart_r, next_tstart;
    logic zoom_r, next_zoom;

    always_comb begin
        // Interval choice
        case (cfg_power_mode)
            PWR_BOOST: intv_len = cfg_zoom_disable ?
                ms_to_cyc(BOOST_FIXED_US) : ms_to_cyc(BOOST_US);
            PWR_NORMAL: intv_len = ms_to_cyc(NORMAL_US);
            PWR_LOW1: intv_len = ms_to_cyc(LOW1_US);
            default: intv_len = ms_to_cyc(LOW2_US);
        endcase
        // Zoom runs boost rate while an event is active
        next_zoom = !cfg_zoom_disable && (prox_det || touch_det);
        if (zoom_r) begin
            intv_len = ms_to_cyc(BOOST_US);
        end
        next_startup = 1'b0;
        next_tstart = 1'b0;
        next_tune_busy = tune_busy_r;
        // Start-up and out-of-range retune
        if (startup || (sample_valid && counts_out_of_range &&
            !tune_busy_r)) begin
            next_tstart = 1'b1;
            next_tune_busy = 1'b1;
        end else if (tune_done) begin
            next_tune_busy = 1'b0;
        end
        next_charge = 1'b0;
        next_intv_cnt = intv_cnt + 32'h1;
        if (intv_cnt + 32'h1 >= intv_len) begin
            next_intv_cnt = '0;
            next_charge = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tune_busy_r <= 1'b0;
            startup <= 1'b1;
            intv_cnt <= '0;
            charge_r <= 1'b0;
            tstart_r <= 1'b0;
            zoom_r <= 1'b0;
        end else begin
            tune_busy_r <= next_tune_busy;
            startup <= next_startup;
            intv_cnt <= next_intv_cnt;
            charge_r <= next_charge;
            tstart_r <= next_tstart;
            zoom_r <= next_zoom;
        end
    end

    // ------------------------------------------------------------
    // Detection, filter halt and fault timeout
    // ------------------------------------------------------------
    logic prox_r, next_prox, touch_r, next_touch;
    logic hold_r, next_hold;
    logic reseed_r, next_reseed;
    logic prox_seen, next_prox_seen;
    logic [31:0] halt_cnt, next_halt_cnt;

    always_comb begin
        next_reseed = 1'b0;
        next_prox_seen = prox_seen;
        // No detection while tuning
        next_prox = prox_raw && !tune_busy_r;
        next_touch = touch_raw && !tune_busy_r;
        if (next_prox) begin
            next_prox_seen = 1'b1;
        end
        // Average held on proximity, released on touch
        next_hold = next_prox && !next_touch;
        // Fast entry touch before proximity holds at reseed point
        if (cfg_fast_touch && next_touch && !prox_seen) begin
            next_hold = 1'b1;
        end
        next_halt_cnt = '0;
        if (next_hold || next_prox) begin
            next_halt_cnt = halt_cnt + 32'h1;
        end
        // Timeout is a fault: reseed, clear detection
        if (cfg_halt_time != HALT_NEVER &&
            halt_cnt >= halt_cyc(cfg_halt_time)) begin
            next_reseed = 1'b1;
            next_hold = 1'b0;
            next_prox = 1'b0;
            next_touch = 1'b0;
            next_halt_cnt = '0;
            next_prox_seen = 1'b0;
        end
        if (!next_prox && !next_touch) begin
            next_prox_seen = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prox_r <= 1'b0;
            touch_r <= 1'b0;
            hold_r <= 1'b0;
            reseed_r <= 1'b0;
            prox_seen <= 1'b0;
            halt_cnt <= '0;
        end else begin
            prox_r <= next_prox;
            touch_r <= next_touch;
            hold_r <= next_hold;
            reseed_r <= next_reseed;
            prox_seen <= next_prox_seen;
            halt_cnt <= next_halt_cnt;
        end
    end

    // ------------------------------------------------------------
    // Stream packet into FIFO
    // ------------------------------------------------------------
    logic [3:0] pk_idx, next_pk_idx;
    logic pk_busy, next_pk_busy;
    logic [7:0] pk_byte;
    logic [7:0] cnt8, next_cnt8;
    logic f_in_ready, f_out_valid, f_out_ready;
    logic [7:0] f_out_data;
    logic [7:0] flags, detb;

    always_comb begin
        // Flag and detection bytes
        flags = 8'h00;
        flags[FLG_ACTIVE_HIGH] = cfg_active_high;
        flags[FLG_FILTER_HALT] = hold_r;
        flags[FLG_LOW_POWER] = cfg_power_mode[1];
        flags[FLG_TUNE_BUSY] = tune_busy_r;
        flags[FLG_NOISE] = noise_found;
        flags[FLG_ZOOM] = zoom_r;
        detb = {touch_r, prox_r, multipliers};
        // Sync first then eight data bytes
        case (pk_idx)
            4'h0: pk_byte = SYNC_BYTE;
            4'h1: pk_byte = sample_counts[15:8];
            4'h2: pk_byte = sample_counts[7:0];
            4'h3: pk_byte = long_term_average[15:8];
            4'h4: pk_byte = long_term_average[7:0];
            4'h5: pk_byte = flags;
            4'h6: pk_byte = detb;
            4'h7: pk_byte = compensation;
            default: pk_byte = cnt8;
        endcase
        next_pk_idx = pk_idx;
        next_pk_busy = pk_busy;
        next_cnt8 = cnt8;
        // A new packet begins per sample_valid result when streaming and no packet is in progress
        if (!pk_busy && sample_valid && cfg_stream_en) begin
            next_pk_busy = 1'b1;
            next_pk_idx = 4'h0;
        end else if (pk_busy && f_in_ready) begin
            if (pk_idx == 4'(DATA_BYTES)) begin
                next_pk_busy = 1'b0;
                next_cnt8 = cnt8 + 8'h01;
            end else begin
                next_pk_idx = pk_idx + 4'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pk_idx <= '0;
            pk_busy <= 1'b0;
            cnt8 <= '0;
        end else begin
            pk_idx <= next_pk_idx;
            pk_busy <= next_pk_busy;
            cnt8 <= next_cnt8;
        end
    end

    csds_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .arst_n(arst_n),
        .in_valid(pk_busy),
        .in_ready(f_in_ready),
        .in_data(pk_byte),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    // ------------------------------------------------------------
    // 1-wire serialiser, I2C hand-off and event pulse
    // ------------------------------------------------------------
    csds_tx_t tx_st, next_tx_st;
    logic [31:0] tx_cnt, next_tx_cnt;
    logic [2:0] tx_bit, next_tx_bit;
    logic [7:0] tx_sh, next_tx_sh;
    logic pin_o, next_pin_o, pin_oe, next_pin_oe;
    logic ow_take;
    logic i2c_v, next_i2c_v;
    logic [7:0] i2c_d, next_i2c_d;
    logic [31:0] ev_cnt, next_ev_cnt;
    logic ev_change;

    always_comb begin
        // Protocol select
        ow_take = !cfg_stream_i2c && tx_st == CSDS_TX_IDLE && f_out_valid;
        f_out_ready = ow_take ||
            (cfg_stream_i2c && (!i2c_v || i2c_byte_ready));
        next_i2c_v = i2c_v;
        next_i2c_d = i2c_d;
        if (cfg_stream_i2c && (!i2c_v || i2c_byte_ready)) begin
            next_i2c_v = f_out_valid;
            next_i2c_d = f_out_data;
        end
        next_tx_st = tx_st;
        next_tx_cnt = tx_cnt + 32'h1;
        next_tx_bit = tx_bit;
        next_tx_sh = tx_sh;
        case (tx_st)
            CSDS_TX_IDLE: begin
                next_tx_cnt = '0;
                if (ow_take) begin
                    next_tx_sh = f_out_data;
                    next_tx_st = CSDS_TX_START;
                end
            end
            CSDS_TX_START: begin
                // Start bit low for start time
                if (tx_cnt + 32'h1 >= 32'(START_CYC)) begin
                    next_tx_cnt = '0;
                    next_tx_bit = '0;
                    next_tx_st = CSDS_TX_BITS;
                end
            end
            CSDS_TX_BITS: begin
                if (tx_cnt + 32'h1 >= 32'(BIT_CYC)) begin
                    next_tx_cnt = '0;
                    next_tx_sh = {1'b0, tx_sh[7:1]};
                    next_tx_bit = tx_bit + 3'h1;
                    if (tx_bit == 3'h7) begin
                        next_tx_st = CSDS_TX_STOP;
                    end
                end
            end
            CSDS_TX_STOP: begin
                // Stop bit high for one bit period
                if (tx_cnt + 32'h1 >= 32'(BIT_CYC)) begin
                    next_tx_st = CSDS_TX_IDLE;
                end
            end
            default: next_tx_st = CSDS_TX_IDLE;
        endcase
        // Event pulse on any detection change
        ev_change = (prox_r != next_prox) || (touch_r != next_touch);
        next_ev_cnt = ev_cnt;
        if (ev_change && cfg_event_mode) begin
            // Scaled by MS_CYC like the interval and halt times so short benches stay short
            next_ev_cnt = ms_to_cyc(EVENT_PULSE_US);
        end else if (ev_cnt != '0) begin
            next_ev_cnt = ev_cnt - 32'h1;
        end
        // Pin function selection
        if (cfg_stream_en && !cfg_stream_i2c) begin
            next_pin_oe = 1'b1;
            case (next_tx_st)
                CSDS_TX_START: next_pin_o = 1'b0;
                CSDS_TX_BITS: next_pin_o = next_tx_sh[0];
                default: next_pin_o = !(cfg_event_mode && next_ev_cnt != '0);
            endcase
        end else begin
            // Active low output is open drain: drive only when low
            next_pin_o = (next_prox || next_touch) ? cfg_active_high
                : !cfg_active_high;
            next_pin_oe = cfg_active_high || !next_pin_o;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tx_st <= CSDS_TX_IDLE;
            tx_cnt <= '0;
            tx_bit <= '0;
            tx_sh <= '0;
            pin_o <= 1'b1;
            pin_oe <= 1'b0;
            i2c_v <= 1'b0;
            i2c_d <= '0;
            ev_cnt <= '0;
        end else begin
            tx_st <= next_tx_st;
            tx_cnt <= next_tx_cnt;
            tx_bit <= next_tx_bit;
            tx_sh <= next_tx_sh;
            pin_o <= next_pin_o;
            pin_oe <= next_pin_oe;
            i2c_v <= next_i2c_v;
            i2c_d <= next_i2c_d;
            ev_cnt <= next_ev_cnt;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------
    logic [15:0] tgt_r;
    logic part_r, acf_r, rsd_r;
    logic [6:0] addr_r;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tgt_r <= TARGET_DEFAULT;
            part_r <= 1'b0;
            acf_r <= 1'b1;
            rsd_r <= 1'b1;
            addr_r <= 7'h00;
        end else begin
            tgt_r <= cfg_target_low ? TARGET_LOW : TARGET_DEFAULT;
            part_r <= cfg_partial_tune;
            acf_r <= !cfg_fast_touch;
            rsd_r <= !cfg_fast_touch;
            addr_r <= (cfg_stream_en && cfg_stream_i2c) ? I2C_ADDR : 7'h00;
        end
    end

    assign charge_start = charge_r;
    assign tune_start = tstart_r;
    assign tune_partial = part_r;
    assign tune_target = tgt_r;
    assign ltavg_hold = hold_r;
    assign reseed = reseed_r;
    assign ac_filter_en = acf_r;
    assign reseed_delay_en = rsd_r;
    assign in_zoom = zoom_r;
    assign i2c_target_addr = addr_r;
    assign i2c_byte_valid = i2c_v;
    assign i2c_byte = i2c_d;
    assign event_out_pin_o = pin_o;
    assign event_out_pin_oe = pin_oe;
    assign tuning_busy = tune_busy_r;
    assign prox_det = prox_r;
    assign touch_det = touch_r;
endmodule

// [sim/csds_sva.sv]
// Port checker for csds_top.
// Assumes bind to csds_top; one clock, async active-low reset.
`timescale 1ns/100ps
module csds_chk
    import csds_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Configuration
    input wire logic cfg_target_low,
    input wire logic cfg_partial_tune,
    input wire logic cfg_fast_touch,
    input wire logic cfg_stream_en,
    input wire logic cfg_stream_i2c,
    input wire logic cfg_active_high,
    // Watched outputs and the I2C ready input
    input wire logic tune_start,
    input wire logic tune_partial,
    input wire logic [15:0] tune_target,
    input wire logic ac_filter_en,
    input wire logic reseed_delay_en,
    input wire logic tuning_busy,
    input wire logic prox_det,
    input wire logic touch_det,
    input wire logic reseed,
    input wire logic [6:0] i2c_target_addr,
    input wire logic i2c_byte_valid,
    input wire logic i2c_byte_ready,
    input wire logic [7:0] i2c_byte,
    input wire logic event_out_pin_o,
    input wire logic event_out_pin_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // ---------------------------------
    // Assertions
    // ---------------------------------
    chk_target_sel: assert property (
        tune_start |=> tune_target ==
        (cfg_target_low ? TARGET_LOW : TARGET_DEFAULT)) else $error("target");
    chk_partial_tune: assert property (
        tune_start |=> tune_partial == cfg_partial_tune) else $error("partial");
    chk_fast_entry: assert property (
        $stable(cfg_fast_touch) [*2] |-> ac_filter_en != cfg_fast_touch
        && reseed_delay_en != cfg_fast_touch) else $error("fast entry");
    chk_tune_busy: assert property (
        tune_start |-> tuning_busy) else $error("busy");
    chk_busy_no_det: assert property (
        tuning_busy [*2] |-> !prox_det && !touch_det) else $error("det");
    chk_i2c_addr: assert property (
        $stable({cfg_stream_en, cfg_stream_i2c}) [*2] |-> i2c_target_addr ==
        (cfg_stream_en && cfg_stream_i2c ? I2C_ADDR : 7'h00)) else $error("addr");
    chk_i2c_hold: assert property (
        i2c_byte_valid && !i2c_byte_ready |=> i2c_byte_valid
        && $stable(i2c_byte)) else $error("i2c hold");
    chk_open_drain: assert property (
        !cfg_stream_en && $stable(cfg_stream_en) && !cfg_active_high
        && event_out_pin_oe |-> !event_out_pin_o) else $error("drain");
    chk_reseed_clr: assert property (
        reseed |-> !prox_det && !touch_det) else $error("reseed");
    cover property (i2c_byte_valid && i2c_byte_ready);
    cover property (reseed);
    cover property (tune_start && cfg_partial_tune);
endmodule
bind csds_top csds_chk csds_chk_i (.*);

// [sim/csds_host.sv]
// Host model capturing the 1-wire stream from the pin.
// Assumes a pull-up on the pin and LSB-first bytes.
`timescale 1ns/100ps
module csds_host #(
    parameter int START_CYC = 8
) (
    // Clock and pin
    input wire logic mclk,
    input wire logic line
);
    logic [7:0] rx_q [$];
    logic [7:0] b;
    int lo, hi, per;
    // ---------------------------------
    // Capture; timing learnt per packet
    // ---------------------------------
    initial begin
        forever begin
            @(negedge line);
            lo = 0;
            hi = 0;
            while (!line) begin @(negedge mclk); lo++; end
            while (line) begin @(negedge mclk); hi++; end
            per = hi;
            rx_q.push_back(lo == START_CYC + per + 1 ? 8'hAA : 8'h00);
            repeat (6 * per + per / 2) @(negedge mclk);
            repeat (8) begin
                @(negedge line);
                repeat (START_CYC + per / 2) @(negedge mclk);
                for (int i = 0; i < 8; i++) begin
                    b[i] = line;
                    repeat (per) @(negedge mclk);
                end
                rx_q.push_back(line ? b : 8'hXX);
            end
        end
    end
endmodule

// [sim/csds_top_bench.sv]
// Bench for csds_top: tuning, 1-wire and I2C packets, halt fault.
// Assumes csds_host on the pin; the pin has a pull-up.
`timescale 1ns/100ps
module csds_top_bench;
    import csds_pkg::*;
    logic mclk = 0, arst_n = 0;
    logic cfg_target_low, cfg_partial_tune, cfg_fast_touch, cfg_zoom_disable;
    logic cfg_stream_en, cfg_stream_i2c, cfg_event_mode, cfg_active_high;
    logic [1:0] cfg_halt_time, cfg_power_mode;
    logic sample_valid, prox_raw, touch_raw, noise_found, counts_out_of_range;
    logic tune_done, i2c_byte_ready, charge_start, tune_start, tune_partial;
    logic ltavg_hold, reseed, ac_filter_en, reseed_delay_en, in_zoom;
    logic i2c_byte_valid, tuning_busy, prox_det, touch_det;
    logic event_out_pin_o, event_out_pin_oe;
    logic [15:0] sample_counts, long_term_average, tune_target;
    logic [5:0] multipliers;
    logic [7:0] compensation, i2c_byte;
    logic [6:0] i2c_target_addr;
    wire event_out_pin_in = event_out_pin_oe ? event_out_pin_o : 1'b1;
    int fails = 0, comparisons = 0, n;
    always #10 mclk = ~mclk;
    csds_top #(.BIT_CYC(4), .START_CYC(8), .MS_CYC(5)) csds_top_i (.*);
    csds_host #(.START_CYC(8)) csds_host_i (.mclk(mclk), .line(event_out_pin_in));
    // ---------------------------------
    // Tasks
    // ---------------------------------
    task automatic wrap_up;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [15:0] e, g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s exp %h got %h", what, e, g);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic limit(input string what, input int k, lim);
        if (k >= lim) begin
            fails++;
            $display("[ERR] %s exp done got timeout", what);
            wrap_up();
        end
    endtask
    task automatic wait_on(input string what, ref logic s, input int lim);
        n = 0;
        while (s !== 1'b1 && n < lim) begin tick(1); n++; end
        limit(what, n, lim);
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        tick(1);
        s = 0;
    endtask
    task automatic check_pkt(input bit i2c, input logic [7:0] cnt);
        logic [7:0] e [9];
        e = '{SYNC_BYTE, 8'h12, 8'h34, 8'h56, 8'h78, 8'h0A, 8'h15, 8'hC3, cnt};
        for (int i = 0; i < 9; i++) begin
            if (i2c) begin
                i2c_byte_ready = 1;
                wait_on("i2c valid", i2c_byte_valid, 500);
                cmp("i2c byte", e[i], i2c_byte);
                tick(1);
            end else begin
                cmp("wire byte", e[i], csds_host_i.rx_q.pop_front());
            end
        end
    endtask
    // ---------------------------------
    // Sequence
    // ---------------------------------
    initial begin
        {cfg_target_low, cfg_partial_tune, cfg_fast_touch, cfg_zoom_disable} = 0;
        {cfg_stream_en, cfg_stream_i2c, cfg_event_mode, cfg_active_high} = 0;
        {cfg_halt_time, cfg_power_mode, i2c_byte_ready} = 0;
        {sample_valid, prox_raw, touch_raw, counts_out_of_range, tune_done} = 0;
        {noise_found, sample_counts, long_term_average} = 33'h1_1234_5678;
        {multipliers, compensation} = 14'h15C3;
        tick(3);
        arst_n = 1;
        wait_on("tune start", tune_start, 5);
        cmp("target", 16'h04B0, tune_target);
        pulse(tune_done);
        tick(2);
        cmp("busy", 0, tuning_busy);
        {cfg_target_low, cfg_partial_tune, cfg_fast_touch, cfg_zoom_disable} = 4'hF;
        cfg_power_mode = 2'h2;
        counts_out_of_range = 1;
        pulse(sample_valid);
        counts_out_of_range = 0;
        wait_on("retune", tune_start, 50);
        tick(1);
        cmp("target", 16'h0400, tune_target);
        cmp("partial", 1, tune_partial);
        cmp("ac filter", 0, ac_filter_en);
        pulse(tune_done);
        cfg_stream_en = 1;
        tick(2);
        pulse(sample_valid);
        tick(12);
        pulse(sample_valid);
        n = 0;
        while (csds_host_i.rx_q.size() < 18 && n < 3000) begin tick(1); n++; end
        limit("wire packets", n, 3000);
        for (int p = 0; p < 2; p++) check_pkt(0, 8'(p));
        cfg_stream_i2c = 1;
        tick(2);
        cmp("i2c addr", 16'h0044, {9'h000, i2c_target_addr});
        pulse(sample_valid);
        tick(12);
        pulse(sample_valid);
        tick(40);
        for (int p = 2; p < 4; p++) check_pkt(1, 8'(p));
        i2c_byte_ready = 0;
        {cfg_stream_en, cfg_stream_i2c, cfg_halt_time} = 4'h3;
        prox_raw = 1;
        n = 0;
        while (prox_det !== 1'b1 && n < 100) begin pulse(sample_valid); n++; end
        limit("prox", n, 100);
        wait_on("halt fault", reseed, 20000);
        cmp("prox after fault", 0, prox_det);
        {cfg_stream_en, cfg_event_mode, cfg_halt_time} = 4'hE;
        tick(1);
        cmp("event pin low", 0, event_out_pin_o);
        tick(7);
        cmp("event pin end", 0, event_out_pin_o);
        tick(1);
        cmp("event pin high", 1, event_out_pin_o);
        prox_raw = 0;
        wrap_up();
    end
endmodule
